//--- rtl/dram_odt_timing_ctrl.sv
// Summary of operation
// RULE1 - Synchronous timing whenever DLL locked
// RULE2 - Pin high/low switches standard termination, delayed
// RULE3 - Pin delay is latencies minus preamble
// RULE4 - Read disables termination after read delay
// RULE5 - Idle termination returns after burst extra
// RULE6 - Controller holds pin high minimum cycles
// RULE7 - Controller lengthens hold for CRC/preamble
// RULE8 - Changes land 0.3 to 0.7 CK late
// RULE9 - No termination while driving read data
// RULE10 - Dynamic mode when A9 or A10 set
// RULE11 - Termination codes from three mode fields
// RULE12 - Pin picks standard, else idle termination
// RULE13 - Write selects store termination after delay
// RULE14 - Store exit adds 4 or 6 cycles
// RULE15 - Other modes add 7, 5/7 or 8
// RULE16 - No dynamic switching with DLL off
// RULE17 - Controller clears store field to disable
// RULE18 - Priority: disable, store, standard, idle
// RULE19 - Pin ignored if standard off or self-refresh
// RULE20 - Per-cycle pipelines, latencies follow mode regs; here latencies come from the programmed latency register instead
`timescale 1ns/10ps
`include "odt_cfg.svh"

module dram_odt_timing_ctrl
(
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RST_B,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // DRAM clock and termination pin
  input  wire logic        CK,
  input  wire logic        ODT,
  // Decoded command strobes, valid around CK rise
  input  wire logic        CMD_WRITE,
  input  wire logic        CMD_READ,
  input  wire logic        CMD_MRS,
  input  wire logic        CMD_BC4,
  input  wire logic [2:0]  BA,
  input  wire logic [13:0] ADDR,
  // Applied termination
  output logic      [3:0]  TERM_MODE,
  output logic      [2:0]  TERM_CODE
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  localparam int PW = 23;         // Width of the pin bundle

  logic [PW-1:0] pin_raw;         // All pins, one vector
  logic [PW-1:0] pin_s1_q;        // First stage, read by second only
  logic [PW-1:0] pin_s2_q;        // Settled copy
  logic          ck_s3_q;         // Delayed CK for edge finding
  logic          tick;            // Sampled CK rising edge

  assign pin_raw = {CK, ODT, CMD_WRITE, CMD_READ, CMD_MRS, CMD_BC4, BA, ADDR};

  // Two flops before any logic looks at a pin
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      ck_s3_q  <= 1'b0;
    end
    else
    begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      ck_s3_q  <= pin_s2_q[PW-1];
    end
  end

  // Pins share one path, so they stay aligned with CK
  assign tick = pin_s2_q[PW-1] & ~ck_s3_q;

  logic        odt_s;             // Settled termination pin
  logic        wr_s;              // Settled write strobe
  logic        rd_s;              // Settled read strobe
  logic        mrs_s;             // Settled mode set strobe
  logic        bc4_s;             // Settled on-the-fly chop
  logic [2:0]  ba_s;              // Settled mode register select
  logic [13:0] addr_s;            // Settled mode register value

  assign odt_s  = pin_s2_q[PW-2];
  assign wr_s   = pin_s2_q[PW-3];
  assign rd_s   = pin_s2_q[PW-4];
  assign mrs_s  = pin_s2_q[PW-5];
  assign bc4_s  = pin_s2_q[PW-6];
  assign ba_s   = pin_s2_q[16:14];
  assign addr_s = pin_s2_q[13:0];

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  logic [31:0] ctrl_q;            // Mode and state control
  logic [31:0] lat_q;             // Programmed latencies
  logic [13:0] mr1_q;             // Mode register one
  logic [13:0] mr2_q;             // Mode register two
  logic [13:0] mr5_q;             // Mode register five
  logic        apb_wr;            // Write completes this edge
  logic        apb_acc;           // First access cycle

  assign apb_acc = PSEL & PENABLE & ~PREADY;
  assign apb_wr  = PSEL & PENABLE & PREADY & PWRITE;

  // Control and latency registers
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      ctrl_q <= `CTRL_RST;
      lat_q  <= `LAT_RST;
    end
    else if (apb_wr)
    begin
      if (PADDR == `OFS_CTRL)
        ctrl_q <= {26'h0, PWDATA[5:0]};
      if (PADDR == `OFS_LAT)
        lat_q <= PWDATA & 32'h1f0f_1f1f;
    end
  end

  // Mode registers load from the mode set command on CK
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      mr1_q <= `MR_RST;
      mr2_q <= `MR_RST;
      mr5_q <= `MR_RST;
    end
    else if (tick && mrs_s)
    begin
      // Selects other than these three are not ours
      if (ba_s == `MR_SEL_ONE)
        mr1_q <= addr_s;
      if (ba_s == `MR_SEL_TWO)
        mr2_q <= addr_s;
      if (ba_s == `MR_SEL_FIVE)
        mr5_q <= addr_s;
    end
  end

  // ----------------------------------------
  // Decoded configuration
  // ----------------------------------------
  logic                dll_on;    // DLL locked
  logic                self_ref;  // Self refresh active
  logic                pre2;      // Two-cycle preamble
  logic                crc_on;    // Write CRC enabled
  odt_pkg::burst_mode_t bmode;    // Burst length mode
  logic [2:0]          nom_code;  // Standard termination code
  logic [2:0]          wr_code;   // Store-phase termination code
  logic [2:0]          park_code; // Idle termination code
  logic                dyn_en;    // Dynamic termination on

  assign dll_on    = ctrl_q[`CTRL_DLL_BIT];
  assign self_ref  = ctrl_q[`CTRL_SR_BIT];
  assign pre2      = ctrl_q[`CTRL_PRE2_BIT];
  assign crc_on    = ctrl_q[`CTRL_CRC_BIT];
  assign bmode     = odt_pkg::burst_mode_t'(ctrl_q[`CTRL_BL_LSB +: 2]);
  assign nom_code  = mr1_q[`MR_NOM_HI:`MR_NOM_LO];    // [RULE11]
  assign wr_code   = mr2_q[`MR_WR_HI:`MR_WR_LO];      // [RULE11]
  assign park_code = mr5_q[`MR_PARK_HI:`MR_PARK_LO];  // [RULE11]
  // A zero store field clears both bits, so it turns this off [RULE10]
  assign dyn_en    = mr2_q[`MR_DYN_A9] | mr2_q[`MR_DYN_A10];

  // ----------------------------------------
  // Latency arithmetic
  // ----------------------------------------
  // Clamp to the delay line; small settings would go negative
  function automatic logic [5:0] sat(input logic [7:0] v);
    logic [5:0] r;
    r = 6'h00;
    if (v[7])
      r = 6'h00;
    else if (v > `DLY_MAX)
      r = 6'(`DLY_MAX);
    else
      r = v[5:0];
    return r;
  endfunction

  logic [7:0] pre_sub;            // Preamble subtraction
  logic [7:0] wl;                 // Total write latency
  logic [7:0] rl;                 // Total read latency
  logic [5:0] pin_dly;            // Pin to standard switch delay
  logic [5:0] rd_off;             // Read to termination off
  logic [5:0] rd_on;              // Read to idle termination back
  logic [5:0] wr_enter;           // Write to store termination
  logic [5:0] wx_chop;            // Store exit, chopped burst
  logic [5:0] wx_full;            // Store exit, full burst
  logic [7:0] park_add;           // Read window length
  logic [7:0] wx_add_c;           // Chop exit extra
  logic [7:0] wx_add_f;           // Full exit extra

  // Recomputed every cycle, so mode changes act at once [RULE20]
  always_comb
  begin
    pre_sub = pre2 ? `PRE_TWO_SUB : `PRE_ONE_SUB;
    wl = 8'(lat_q[`LAT_CWL_LSB +: 5]) + 8'(lat_q[`LAT_AL_LSB +: 5])
       + 8'(lat_q[`LAT_PL_LSB +: 4]);
    rl = 8'(lat_q[`LAT_CL_LSB +: 5]) + 8'(lat_q[`LAT_AL_LSB +: 5])
       + 8'(lat_q[`LAT_PL_LSB +: 4]);
    // Fixed chop ends sooner; otherwise allow a full burst
    if (bmode == odt_pkg::BURST_CHOP)
      park_add = pre2 ? `PARK_CHOP_P2 : `PARK_CHOP_P1;  // [RULE5]
    else
      park_add = pre2 ? `PARK_FULL_P2 : `PARK_FULL_P1;  // [RULE5]
    // Exit extras per preamble and CRC
    case ({pre2, crc_on})
      2'b00:
      begin
        wx_add_c = `WX_P1_CHOP;                         // [RULE14]
        wx_add_f = `WX_P1_FULL;                         // [RULE14]
      end
      2'b01:
      begin
        wx_add_c = `WX_P1_CRC;                          // [RULE15]
        wx_add_f = `WX_P1_CRC;
      end
      2'b10:
      begin
        wx_add_c = `WX_P2_CHOP;                         // [RULE15]
        wx_add_f = `WX_P2_FULL;
      end
      default:
      begin
        wx_add_c = `WX_P2_CRC;                          // [RULE15]
        wx_add_f = `WX_P2_CRC;
      end
    endcase
    pin_dly  = sat(wl - pre_sub);                       // [RULE3]
    rd_off   = sat(rl - pre_sub);                       // [RULE4]
    rd_on    = sat(8'(rd_off) + park_add);              // [RULE5]
    wr_enter = sat(wl - pre_sub);                       // [RULE13]
    wx_chop  = sat(8'(wr_enter) + wx_add_c);
    wx_full  = sat(8'(wr_enter) + wx_add_f);
  end

  // ----------------------------------------
  // Event inputs to the delay lines
  // ----------------------------------------
  logic pin_ev;                   // Pin counts toward standard
  logic rd_ev;                    // Read registered
  logic wr_chop_ev;               // Chopped write registered
  logic wr_full_ev;               // Full write registered
  logic wr_chop;                  // This write is chopped

  always_comb
  begin
    case (bmode)
      odt_pkg::BURST_CHOP: wr_chop = 1'b1;
      odt_pkg::BURST_OTF:  wr_chop = bc4_s;
      default:             wr_chop = 1'b0;
    endcase
  end

  // Pin ignored if standard code is zero or in self refresh [RULE19]
  assign pin_ev     = odt_s & (nom_code != 3'h0) & ~self_ref;
  assign rd_ev      = rd_s & ~self_ref;
  // Dynamic switching only with the DLL locked [RULE16] [RULE13]
  assign wr_chop_ev = wr_s & dyn_en & dll_on & wr_chop;
  assign wr_full_ev = wr_s & dyn_en & dll_on & ~wr_chop;

  // ----------------------------------------
  // Per-cycle delay lines
  // ----------------------------------------
  logic pin_win;                  // Standard window, delayed pin
  logic rd_win;                   // Read drive window
  logic wrc_win;                  // Store window, chopped writes
  logic wrf_win;                  // Store window, full writes

  // Same delay for rise and fall of the pin [RULE2] [RULE20]
  odt_delay_window u_pin
  (
    .clk   (REF_CLK),
    .rst_b (RST_B),
    .tick  (tick),
    .din   (pin_ev),
    .lo    (pin_dly),
    .hi    (pin_dly + 6'h01),
    .win_q (pin_win)
  );

  // Off from read delay until the postamble ends [RULE4] [RULE9]
  odt_delay_window u_read
  (
    .clk   (REF_CLK),
    .rst_b (RST_B),
    .tick  (tick),
    .din   (rd_ev),
    .lo    (rd_off),
    .hi    (rd_on),
    .win_q (rd_win)
  );

  // Store window for chopped writes [RULE14]
  odt_delay_window u_wr_chop
  (
    .clk   (REF_CLK),
    .rst_b (RST_B),
    .tick  (tick),
    .din   (wr_chop_ev),
    .lo    (wr_enter),
    .hi    (wx_chop),
    .win_q (wrc_win)
  );

  // Store window for full writes [RULE14]
  odt_delay_window u_wr_full
  (
    .clk   (REF_CLK),
    .rst_b (RST_B),
    .tick  (tick),
    .din   (wr_full_ev),
    .lo    (wr_enter),
    .hi    (wx_full),
    .win_q (wrf_win)
  );

  // ----------------------------------------
  // Termination selection
  // ----------------------------------------
  odt_pkg::term_mode_t mode_d;    // Mode to apply
  logic [2:0]          code_d;    // Code to apply
  logic                nom_req;   // Standard requested now

  // Without lock the pin acts undelayed; full async timing is not modelled
  assign nom_req = dll_on ? pin_win : pin_ev;           // [RULE1]

  // Fixed order: disable, store, standard, idle [RULE18]
  always_comb
  begin
    mode_d = odt_pkg::TERM_OFF;
    code_d = 3'h0;
    if (self_ref || rd_win)
    begin
      // Driving read data, never terminate [RULE9]
      mode_d = odt_pkg::TERM_OFF;
      code_d = 3'h0;
    end
    else if (wrc_win || wrf_win)
    begin
      mode_d = odt_pkg::TERM_WR;                        // [RULE13]
      code_d = wr_code;
    end
    else if (nom_req)
    begin
      mode_d = odt_pkg::TERM_NOM;                       // [RULE12]
      code_d = nom_code;
    end
    else if (park_code != 3'h0)
    begin
      mode_d = odt_pkg::TERM_PARK;                      // [RULE12]
      code_d = park_code;
    end
  end

  // ----------------------------------------
  // Change skew and outputs
  // ----------------------------------------
  logic [3:0] skew_cnt_q;         // Cycles left before applying

  // Started on each CK edge; the wait lands inside the skew window
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
      skew_cnt_q <= 4'h0;
    else if (tick)
      skew_cnt_q <= 4'(`SKEW_WAIT_CYC);                 // [RULE8]
    else if (skew_cnt_q != 4'h0)
      skew_cnt_q <= skew_cnt_q - 4'h1;
  end

  // Outputs move only when the wait expires
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      TERM_MODE <= odt_pkg::TERM_OFF;
      TERM_CODE <= 3'h0;
    end
    else if (skew_cnt_q == 4'h1)
    begin
      TERM_MODE <= mode_d;                              // [RULE8]
      TERM_CODE <= code_d;
    end
  end

  // ----------------------------------------
  // APB answer
  // ----------------------------------------
  logic [31:0] rd_mux;            // Read data selection
  logic        bad_addr;          // Unmapped offset

  // Status read shows the live windows and latency
  always_comb
  begin
    rd_mux   = 32'h0;
    bad_addr = 1'b0;
    case (PADDR)
      `OFS_CTRL: rd_mux = ctrl_q;
      `OFS_LAT:  rd_mux = lat_q;
      `OFS_MR1:  rd_mux = {18'h0, mr1_q};
      `OFS_MR2:  rd_mux = {18'h0, mr2_q};
      `OFS_MR5:  rd_mux = {18'h0, mr5_q};
      `OFS_STAT: rd_mux = {16'h0, pin_dly, wrc_win | wrf_win, rd_win,
                           pin_win, TERM_CODE, TERM_MODE};
      default:   bad_addr = 1'b1;
    endcase
  end

  // One wait state; data and error land with ready
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY  <= apb_acc;
      PSLVERR <= apb_acc & bad_addr;
      if (apb_acc && !PWRITE)
        PRDATA <= rd_mux;
    end
  end

endmodule

//--- rtl/odt_cfg.svh
`ifndef ODT_CFG_SVH
`define ODT_CFG_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define OFS_CTRL        12'h000
`define OFS_LAT         12'h004
`define OFS_MR1         12'h008
`define OFS_MR2         12'h00c
`define OFS_MR5         12'h010
`define OFS_STAT        12'h014

// ----------------------------------------
// Control field positions
// ----------------------------------------
`define CTRL_DLL_BIT    0
`define CTRL_SR_BIT     1
`define CTRL_PRE2_BIT   2
`define CTRL_CRC_BIT    3
`define CTRL_BL_LSB     4
`define CTRL_RST        32'h0000_0000

// Latency field positions
`define LAT_CWL_LSB     0
`define LAT_AL_LSB      8
`define LAT_PL_LSB      16
`define LAT_CL_LSB      24
`define LAT_RST         32'h0000_0009

// Mode register fields and selects
`define MR_NOM_HI       10
`define MR_NOM_LO       8
`define MR_WR_HI        11
`define MR_WR_LO        9
`define MR_PARK_HI      8
`define MR_PARK_LO      6
`define MR_DYN_A9       9
`define MR_DYN_A10      10
`define MR_SEL_ONE      3'h1
`define MR_SEL_TWO      3'h2
`define MR_SEL_FIVE     3'h5
`define MR_RST          14'h0000

// ----------------------------------------
// Latency arithmetic
// ----------------------------------------
`define DLY_DEPTH       64
`define DLY_MAX         8'h3e
`define PRE_ONE_SUB     8'h02
`define PRE_TWO_SUB     8'h03
`define PARK_CHOP_P1    8'h04
`define PARK_CHOP_P2    8'h05
`define PARK_FULL_P1    8'h06
`define PARK_FULL_P2    8'h07
`define WX_P1_CHOP      8'h04
`define WX_P1_FULL      8'h06
`define WX_P1_CRC       8'h07
`define WX_P2_CHOP      8'h05
`define WX_P2_FULL      8'h07
`define WX_P2_CRC       8'h08

// ----------------------------------------
// Timing: change skew after latency point
// ----------------------------------------
`define REF_PERIOD_NS   10
`define CK_PERIOD_NS    160
`define SKEW_MIN_X10    3
`define SKEW_MAX_X10    7
`define SKEW_WAIT_CYC   ((`SKEW_MIN_X10*`CK_PERIOD_NS+10*`REF_PERIOD_NS-1)/(10*`REF_PERIOD_NS))
`define SKEW_MAX_CYC    ((`SKEW_MAX_X10*`CK_PERIOD_NS)/(10*`REF_PERIOD_NS))

`endif

//--- rtl/odt_delay_window.sv
`timescale 1ns/10ps
`include "odt_cfg.svh"

// Per-CK-cycle shift line; flags when any event sits in [lo, hi)
module odt_delay_window
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // One pulse per sampled CK rising edge
  input  wire logic       tick,
  input  wire logic       din,
  // Window bounds in CK cycles
  input  wire logic [5:0] lo,
  input  wire logic [5:0] hi,
  // Registered window flag
  output logic            win_q
);

  logic [`DLY_DEPTH-1:0] sr_q;    // Event history, bit n = n cycles ago
  logic [`DLY_DEPTH-1:0] sr_d;    // History after this tick
  logic [`DLY_DEPTH-1:0] mask;    // Bits inside the window

  // ----------------------------------------
  // Shift and window mask
  // ----------------------------------------
  always_comb
  begin
    sr_d = {sr_q[`DLY_DEPTH-2:0], din};
    mask = '0;
    for (int i = 0; i < `DLY_DEPTH; i++)
    begin
      // Overlapping events merge into one long window
      mask[i] = (6'(i) >= lo) && (6'(i) < hi);
    end
  end

  // History advances only on CK edges
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      sr_q <= '0;
    else if (tick)
      sr_q <= sr_d;
  end

  // Window flag follows the same edge
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      win_q <= 1'b0;
    else if (tick)
      win_q <= |(sr_d & mask);
  end

endmodule

//--- rtl/odt_pkg.sv
package odt_pkg;

  // Termination actually applied, one-hot
  typedef enum logic [3:0]
  {
    TERM_OFF  = 4'b0001,
    TERM_PARK = 4'b0010,
    TERM_NOM  = 4'b0100,
    TERM_WR   = 4'b1000
  } term_mode_t;

  // Burst mode selection
  typedef enum logic [1:0]
  {
    BURST_FULL = 2'b01,
    BURST_OTF  = 2'b10,
    BURST_CHOP = 2'b11
  } burst_mode_t;

endpackage

//--- verif/ctl_model.sv
`timescale 1ns/10ps
module ctl_model
(
  // Link clock and pin
  output logic        ck,
  output logic        odt,
  // Command strobes and mode value
  output logic        wr,
  output logic        rd,
  output logic        mode_register_set,
  output logic        bc4,
  output logic [2:0]  ba,
  output logic [13:0] addr
);
  int      ck_cnt; // Rising edges so far
  realtime t_rise; // Time of last rise
  // Free running link clock
  initial
  begin
    {ck, odt, wr, rd, mode_register_set, bc4, ba, addr} = '0;
    ck_cnt = 0;
    t_rise = 0;
    #3;
    forever #80 ck = ~ck;
  end
  // Edge count for the bench
  always @(posedge ck)
  begin
    ck_cnt = ck_cnt + 1;
    t_rise = $realtime;
  end
  // One link cycle, moved at the fall
  task put(input logic o, input logic [2:0] c, input logic b, input logic [2:0] s,
           input logic [13:0] a);
    @(negedge ck);
    odt <= o;
    {mode_register_set, rd, wr} <= c;
    bc4 <= b;
    ba <= s;
    addr <= a;
  endtask
  // Idle cycles, loose lines toggle
  task hold(input int k);
    repeat (k) put(odt, 3'h0, ~bc4, ~ba, ~addr);
  endtask
endmodule

//--- verif/dram_odt_timing_ctrl_bench.sv
`timescale 1ns/10ps
`include "odt_cfg.svh"
module dram_odt_timing_ctrl_bench;
  // ----
  // Signals
  // ----
  logic        REF_CLK = 1'b0;
  logic        RST_B   = 1'b0;
  logic        PSEL    = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE  = 1'b0;
  logic [11:0] PADDR   = 12'h000;
  logic [31:0] PWDATA  = 32'h0;
  logic [31:0] PRDATA;
  logic        PREADY;
  logic        PSLVERR;
  logic        CK, ODT, WR, RD, MODE_REGISTER_SET, BC4;
  logic [2:0]  BA;
  logic [13:0] ADDR;
  logic [3:0]  TERM_MODE;
  logic [2:0]  TERM_CODE;
  int          mismatches = 0;
  int          checked = 0;
  // Mode table
  logic [5:0]  tctl [6] = '{6'h31, 6'h11, 6'h29, 6'h25, 6'h15, 6'h3d};
  int          tre [6]  = '{4, 6, 6, 7, 7, 5};
  int          twe [6]  = '{4, 6, 7, 5, 7, 8};
  logic        tbc [6]  = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
  always #5 REF_CLK = ~REF_CLK;
  dram_odt_timing_ctrl dram_odt_timing_ctrl_i (.CMD_WRITE(WR), .CMD_READ(RD), .CMD_MRS(MODE_REGISTER_SET),
    .CMD_BC4(BC4), .*);
  ctl_model ctl_model_i (.ck(CK), .odt(ODT), .wr(WR), .rd(RD), .mode_register_set(MODE_REGISTER_SET), .bc4(BC4),
    .ba(BA), .addr(ADDR));
  // ----
  // Shared tasks
  // ----
  task close_out;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task give_up;
    mismatches++;
    close_out;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One bus access
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
           output logic e);
    int n;
    n = 0;
    @(posedge REF_CLK);
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {2'b10, w, a, d};
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    @(posedge REF_CLK);
    while (PREADY !== 1'b1 && n < 20)
    begin
      @(posedge REF_CLK);
      n++;
    end
    if (n == 20)
      give_up;
    r = PRDATA;
    e = PSLVERR;
    {PSEL, PENABLE} <= 2'b00;
  endtask
  task rchk(input string s, input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(s, x, r);
    chk("error flag", {31'h0, xe}, {31'h0, e});
  endtask
  task wreg(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task mr(input logic [2:0] s, input logic [13:0] a);
    ctl_model_i.put(1'b0, 3'h4, 1'b0, s, a);
    ctl_model_i.hold(1);
  endtask
  // Wait for a mode, then judge it
  task wait_term(input logic [3:0] m, input logic [2:0] c, input int n);
    int k;
    k = 0;
    while (TERM_MODE !== m && k < 600)
    begin
      @(posedge REF_CLK);
      k++;
    end
    if (k == 600)
      give_up;
    chk("term code", {29'h0, c}, {29'h0, TERM_CODE});
    if (n >= 0)
      chk("term edge", n, ctl_model_i.ck_cnt);
    if (k > 0)
      chk("term skew", 1, $realtime - ctl_model_i.t_rise inside {[48:122]});
  endtask
  task never(input logic [3:0] m, input int cyc);
    int hits;
    hits = 0;
    repeat (cyc)
    begin
      @(posedge REF_CLK);
      hits += (TERM_MODE === m);
    end
    chk("forbidden mode", 0, hits);
  endtask
  task cmd(input logic o, input logic [2:0] c, input logic b);
    ctl_model_i.put(o, c, b, 3'h0, 14'h0000);
  endtask
  task pin(input int k);
    cmd(1'b1, 3'h0, 1'b0);
    ctl_model_i.hold(k);
    cmd(1'b0, 3'h0, 1'b0);
  endtask
  // ----
  // Scenarios
  // ----
  task regs_case;
    rchk("ctrl", `OFS_CTRL, `CTRL_RST, 1'b0);
    rchk("lat", `OFS_LAT, `LAT_RST, 1'b0);
    rchk("mr1", `OFS_MR1, 32'h0, 1'b0);
    rchk("hole", 12'h018, 32'h0, 1'b1);
    wreg(12'h018, 32'hffff_ffff);
    wreg(`OFS_MR1, 32'h0000_3fff);
    rchk("mr1 ro", `OFS_MR1, 32'h0, 1'b0);
    wreg(`OFS_LAT, 32'h0b00_0009);
    rchk("lat rw", `OFS_LAT, 32'h0b00_0009, 1'b0);
    wreg(`OFS_CTRL, 32'h0000_0011);
    rchk("ctrl rw", `OFS_CTRL, 32'h0000_0011, 1'b0);
  endtask
  task setup_case;
    mr(3'h1, 14'h0300);
    mr(3'h5, 14'h0040);
    mr(3'h2, 14'h0400);
    rchk("mr1", `OFS_MR1, 32'h0000_0300, 1'b0);
    rchk("mr5", `OFS_MR5, 32'h0000_0040, 1'b0);
    wait_term(odt_pkg::TERM_PARK, 3'h1, -1);
  endtask
  task pin_case(input logic [5:0] ctl);
    int n;
    int pre;
    wreg(`OFS_CTRL, {26'h0, ctl});
    pre = ctl[2] ? 3 : 2;
    cmd(1'b1, 3'h0, 1'b0);
    n = ctl_model_i.ck_cnt + 1;
    fork
      pin(pre + 2);
    join_none
    wait_term(odt_pkg::TERM_NOM, 3'h3, n + 9 - pre);
    wait_term(odt_pkg::TERM_PARK, 3'h1, n + 13);
  endtask
  task prio_case;
    int n;
    wreg(`OFS_CTRL, 32'h0000_0011);
    cmd(1'b1, 3'h1, 1'b0);
    n = ctl_model_i.ck_cnt + 1;
    fork
      pin(8);
    join_none
    wait_term(odt_pkg::TERM_WR, 3'h2, n + 7);
    wait_term(odt_pkg::TERM_NOM, 3'h3, n + 13);
    wait_term(odt_pkg::TERM_PARK, 3'h1, n + 17);
  endtask
  task rw_case(input logic [5:0] ctl, input logic b, input int re, input int we,
               input logic [2:0] c);
    int n;
    int pre;
    wreg(`OFS_CTRL, {26'h0, ctl});
    pre = ctl[2] ? 3 : 2;
    cmd(1'b0, 3'h2, 1'b0);
    n = ctl_model_i.ck_cnt + 1;
    ctl_model_i.hold(1);
    wait_term(odt_pkg::TERM_OFF, 3'h0, n + 11 - pre);
    wait_term(odt_pkg::TERM_PARK, 3'h1, n + 11 - pre + re);
    cmd(1'b0, 3'h1, b);
    n = ctl_model_i.ck_cnt + 1;
    ctl_model_i.hold(1);
    wait_term(odt_pkg::TERM_WR, c, n + 9 - pre);
    wait_term(odt_pkg::TERM_PARK, 3'h1, n + 9 - pre + we);
  endtask
  task off_case;
    wreg(`OFS_CTRL, 32'h0000_0010);
    cmd(1'b0, 3'h1, 1'b0);
    ctl_model_i.hold(1);
    never(odt_pkg::TERM_WR, 400);
    wreg(`OFS_CTRL, 32'h0000_0013);
    wait_term(odt_pkg::TERM_OFF, 3'h0, -1);
    pin(5);
    never(odt_pkg::TERM_NOM, 300);
    wreg(`OFS_CTRL, 32'h0000_0011);
    wait_term(odt_pkg::TERM_PARK, 3'h1, -1);
    mr(3'h1, 14'h0000);
    pin(5);
    never(odt_pkg::TERM_NOM, 300);
    mr(3'h2, 14'h0000);
    cmd(1'b0, 3'h1, 1'b0);
    ctl_model_i.hold(1);
    never(odt_pkg::TERM_WR, 400);
  endtask
  // ----
  // Main sequence
  // ----
  initial
  begin
    repeat (10) @(posedge REF_CLK);
    RST_B <= 1'b1;
    regs_case;
    setup_case;
    pin_case(6'h11);
    pin_case(6'h15);
    prio_case;
    for (int i = 0; i < 6; i++)
      rw_case(tctl[i], tbc[i], tre[i], twe[i], 3'h2);
    mr(3'h2, 14'h0200);
    rw_case(6'h11, 1'b0, 6, 6, 3'h1);
    off_case;
    close_out;
  end
endmodule

//--- verif/odt_chk_assertions.sv
`timescale 1ns/10ps
module odt_chk
(
  // Clock and reset
  input wire logic        REF_CLK,
  input wire logic        RST_B,
  // Register bus
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // Link side
  input wire logic        CK,
  input wire logic [3:0]  TERM_MODE,
  input wire logic [2:0]  TERM_CODE
);
  // ----
  // Link edge age
  // ----
  logic       ck_q;  // Sampled link clock
  logic [4:0] age_q; // Cycles since link rise, saturates
  // Restart at each sampled rise
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      ck_q  <= 1'b0;
      age_q <= 5'h1f;
    end
    else
    begin
      ck_q <= CK;
      if (CK && !ck_q)
        age_q <= 5'h00;
      else if (age_q != 5'h1f)
        age_q <= age_q + 5'h01;
    end
  end
  // ----
  // Properties
  // ----
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  sequence s_taken;
    PSEL && PENABLE && !PREADY;
  endsequence
  sequence s_pulse;
    PREADY ##1 !PREADY;
  endsequence
  property p_one_wait;
    s_taken |=> s_pulse;
  endproperty
  property p_quiet;
    !(PSEL && PENABLE) |=> !PREADY;
  endproperty
  property p_err_ready;
    PSLVERR |-> PREADY;
  endproperty
  property p_err_data;
    PSLVERR && !PWRITE |-> PRDATA == 32'h0000_0000;
  endproperty
  property p_data_hold;
    $changed(PRDATA) |-> PREADY && !PWRITE;
  endproperty
  property p_onehot;
    $onehot(TERM_MODE);
  endproperty
  property p_off_code;
    TERM_MODE == odt_pkg::TERM_OFF |-> TERM_CODE == 3'h0;
  endproperty
  // One cycle of slack each side
  property p_skew;
    $changed(TERM_MODE) |-> age_q >= 5'h03 && age_q <= 5'h0b;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("late answer");
  a_quiet: assert property (p_quiet) else $error("stray answer");
  a_err_ready: assert property (p_err_ready) else $error("stray error");
  a_err_data: assert property (p_err_data) else $error("refused read data");
  a_data_hold: assert property (p_data_hold) else $error("stray read data");
  a_onehot: assert property (p_onehot) else $error("mode not one-hot");
  a_off_code: assert property (p_off_code) else $error("code while off");
  a_skew: assert property (p_skew) else $error("change off window");
endmodule

bind dram_odt_timing_ctrl odt_chk odt_chk_i (.*);
